// ### hw/ugpfm_top.sv
// pin-function mux for general pins and uart flow-control pins
// assumes a classic wishbone master and synchronous pin levels
// Summary of operation
// (R01) each general pin is input, push-pull, open-drain or event source
// (R02) transmit sync bit 7 puts reference clock on pins 0, 4, 8
// (R03) second timer bit 7 puts timer output on pins 1 and 5
// (R04) each request-to-send pin level is set by a line control bit
// (R05) clock source bit 7 puts uart clock on request-to-send pins
// (R06) each clear-to-send input is a flow-control status input
// (R07) each uart has one receive input and one transmit output
// (R08) interrupt output asserted low while any unmasked event pends
// (R09) with selection bit 0 the pin keeps its normal function
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ugpfm_top
   import ugpfm_pkg::*;
#(
   parameter int NUART = 2
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [7:0]       adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic                  ack_o,
   output logic [31:0]           dat_o,
   input  wire logic             ref_clk_i,
   input  wire logic             timer_i,
   input  wire logic [NUART-1:0] uart_clk_i,
   input  wire logic [NPINS-1:0] gpio_i,
   output logic [NPINS-1:0]      gpio_o,
   output logic [NPINS-1:0]      gpio_oe_o,
   output logic [NUART-1:0]      rts_n_o,
   input  wire logic [NUART-1:0] cts_n_i,
   output logic [NUART-1:0]      uart_cts_n_o,
   input  wire logic [NUART-1:0] rx_i,
   output logic [NUART-1:0]      uart_rxd_o,
   input  wire logic [NUART-1:0] uart_txd_i,
   output logic [NUART-1:0]      tx_o,
   output logic                  irq_n_o,
   output logic                  irq_oe_o
);
   localparam int STW = NPINS + NUART;

   ugpfm_wb_req_s           req;
   logic                    wr;
   logic                    rd;
   logic [31:0]             rdata;
   logic [2*NPINS-1:0]      mode_q;
   logic [NPINS-1:0]        out_q;
   logic [7:0]              txs_q;
   logic [7:0]              tmr2_q;
   logic [7:0]              clks_q;
   logic [7:0]              lcr_q [NUART];
   logic [STW-1:0]          stat_q;
   logic [STW-1:0]          mask_q;
   logic [STW-1:0]          ev;
   logic [NPINS-1:0]        lvl;
   logic [NPINS-1:0]        pev;
   logic [NUART-1:0]        cts_q;
   logic [NUART-1:0]        cts_ev;
   logic                    rd_stat;

   // bus request carried as one struct
   assign req.adr = adr_i;
   assign req.we  = we_i;
   assign req.sel = sel_i;
   assign req.dat = dat_i;

   // byte-lane merge of a write into an old value
   function automatic logic [31:0] merge
   (
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0]  sel
   );
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (nw & m);
   endfunction

   // bus handshake
   ugpfm_wb_slave u_wb
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .cyc_i   (cyc_i),
      .stb_i   (stb_i),
      .we_i    (req.we),
      .rdata_i (rdata),
      .ack_o   (ack_o),
      .dat_o   (dat_o),
      .wr_o    (wr),
      .rd_o    (rd)
   );

   // pin mode and output level registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_q <= RST_ZERO[2*NPINS-1:0];
         out_q  <= RST_ZERO[NPINS-1:0];
      end
      else if (wr && req.adr == OFS_PIN_MODE)
         mode_q <= (2*NPINS)'(merge(32'(mode_q), req.dat, req.sel)); // see (R01)
      else if (wr && req.adr == OFS_PIN_OUT)
         out_q <= NPINS'(merge(32'(out_q), req.dat, req.sel));
   end

   // alternate function selection registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         txs_q  <= RST_ZERO[7:0];
         tmr2_q <= RST_ZERO[7:0];
         clks_q <= RST_ZERO[7:0];
      end
      else if (wr && req.sel[0])
      begin
         if (req.adr == OFS_TX_SYNC)
            txs_q <= req.dat[7:0];
         if (req.adr == OFS_SECOND_TIMER_CONTROL)
            tmr2_q <= req.dat[7:0];
         if (req.adr == OFS_CLK_SRC)
            clks_q <= req.dat[7:0];
      end
   end

   // interrupt mask register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask_q <= RST_ZERO[STW-1:0];
      else if (wr && req.adr == OFS_IRQ_MASK)
         mask_q <= STW'(merge(32'(mask_q), req.dat, req.sel));
   end

   // per general pin: cell with mode and alternate routing
   for (genvar i = 0; i < NPINS; i++)
   begin : g_pin
      ugpfm_pin_cfg_s cfg;
      assign cfg.mode    = ugpfm_mode_e'(mode_q[2*i +: 2]);
      assign cfg.level   = out_q[i];
      assign cfg.alt_en  = (REFCLK_PINS[i] & txs_q[ALT_BIT])
                         | (TIMER_PINS[i] & tmr2_q[ALT_BIT]); // see (R02) see (R03) see (R09)
      assign cfg.alt_val = REFCLK_PINS[i] ? ref_clk_i : timer_i;
      ugpfm_pin_cell u_cell
      (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .cfg_i    (cfg),
         .pin_i    (gpio_i[i]),
         .pin_o    (gpio_o[i]),
         .pin_oe_o (gpio_oe_o[i]),
         .level_o  (lvl[i]),
         .event_o  (pev[i])
      );
   end

   // per uart: line control, rts, cts, serial data
   for (genvar c = 0; c < NUART; c++)
   begin : g_uart
      localparam logic [7:0] OFS = 8'(OFS_LINE_CTL + 4 * c);
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            lcr_q[c] <= RST_LCR;
         else if (wr && req.sel[0] && req.adr == OFS)
            lcr_q[c] <= req.dat[7:0];
      end
      // rts: software level or uart clock when selected
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            rts_n_o[c] <= RST_LCR[RTS_BIT];
         else if (clks_q[ALT_BIT])
            rts_n_o[c] <= uart_clk_i[c]; // see (R05)
         else
            rts_n_o[c] <= lcr_q[c][RTS_BIT]; // see (R04) see (R09)
      end
      // pin stage toward the uart core and the line
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            cts_q[c]        <= 1'b1;
            uart_cts_n_o[c] <= 1'b1;
            uart_rxd_o[c]   <= 1'b1;
            tx_o[c]         <= 1'b1;
         end
         else
         begin
            cts_q[c]        <= cts_n_i[c]; // see (R06)
            uart_cts_n_o[c] <= cts_n_i[c];
            uart_rxd_o[c]   <= rx_i[c]; // see (R07)
            tx_o[c]         <= uart_txd_i[c]; // see (R07)
         end
      end
      assign cts_ev[c] = cts_q[c] != cts_n_i[c];
   end

   // event vector: pin events low, cts changes high
   assign ev      = {cts_ev, pev};
   assign rd_stat = rd && req.adr == OFS_IRQ_STAT;

   // sticky status, a read clears only the bits it returned, a new event wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stat_q <= RST_ZERO[STW-1:0];
      else
         stat_q <= (stat_q & ~(rd_stat ? dat_o[STW-1:0] : '0)) | ev; // see (R08)
   end

   // open-drain interrupt, drives low while pending
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_n_o  <= 1'b0;
         irq_oe_o <= 1'b0;
      end
      else
      begin
         irq_n_o  <= 1'b0;
         irq_oe_o <= |(stat_q & mask_q); // see (R08)
      end
   end

   // read data mux, unmapped reads as zero
   always_comb
   begin
      rdata = RST_ZERO;
      unique case (req.adr)
         OFS_PIN_MODE: rdata[2*NPINS-1:0] = mode_q;
         OFS_PIN_OUT:  rdata[NPINS-1:0]   = out_q;
         OFS_PIN_IN:   rdata[NPINS-1:0]   = lvl;
         OFS_TX_SYNC:  rdata[7:0]         = txs_q;
         OFS_SECOND_TIMER_CONTROL:   rdata[7:0]         = tmr2_q;
         OFS_CLK_SRC:  rdata[7:0]         = clks_q;
         OFS_IRQ_STAT: rdata[STW-1:0]     = stat_q;
         OFS_IRQ_MASK: rdata[STW-1:0]     = mask_q;
         OFS_CTS_STAT: rdata[NUART-1:0]   = cts_q;
         default:
         begin
            for (int k = 0; k < NUART; k++)
               if (req.adr == 8'(OFS_LINE_CTL + 4 * k))
                  rdata[7:0] = lcr_q[k];
         end
      endcase
   end

   // reference clock reaches pin 0 one cycle later
   a_refclk_route: assert property (@(posedge clk_i) disable iff (rst_i) // see (R02)
      txs_q[ALT_BIT] && $stable(txs_q) |=> gpio_o[0] == $past(ref_clk_i) && gpio_oe_o[0])
      else $error("reference clock not on pin 0");

   // timer reaches pin 5 one cycle later
   a_timer_route: assert property (@(posedge clk_i) disable iff (rst_i) // see (R03)
      tmr2_q[ALT_BIT] && $stable(tmr2_q) |=> gpio_o[5] == $past(timer_i) && gpio_oe_o[5])
      else $error("timer output not on pin 5");

   // push-pull pin 2 follows its level
   a_push_pull: assert property (@(posedge clk_i) disable iff (rst_i) // see (R01)
      mode_q[5:4] == MODE_PUSH && $stable(mode_q) |=> gpio_oe_o[2] && gpio_o[2] == $past(out_q[2]))
      else $error("push-pull pin 2 wrong");

   // open-drain pin 3 only ever pulls low
   a_open_drain: assert property (@(posedge clk_i) disable iff (rst_i) // see (R01)
      mode_q[7:6] == MODE_DRAIN && $stable(mode_q) |=> !gpio_o[3] && gpio_oe_o[3] == !$past(out_q[3]))
      else $error("open-drain pin 3 wrong");

   // rts follows line control when clock is not selected
   a_rts_level: assert property (@(posedge clk_i) disable iff (rst_i) // see (R04)
      !clks_q[ALT_BIT] |=> rts_n_o[0] == $past(lcr_q[0][RTS_BIT]))
      else $error("rts level not from line control");

   // rts carries the uart clock when selected
   a_rts_clock: assert property (@(posedge clk_i) disable iff (rst_i) // see (R05)
      clks_q[ALT_BIT] |=> rts_n_o[0] == $past(uart_clk_i[0]))
      else $error("rts not carrying uart clock");

   // cts status mirrors the pin with one cycle delay
   a_cts_status: assert property (@(posedge clk_i) disable iff (rst_i) // see (R06)
      ##1 cts_q == $past(cts_n_i) && uart_cts_n_o == $past(cts_n_i))
      else $error("cts status lags wrongly");

   // serial data passes one cycle late
   a_serial_pass: assert property (@(posedge clk_i) disable iff (rst_i) // see (R07)
      ##1 tx_o == $past(uart_txd_i) && uart_rxd_o == $past(rx_i))
      else $error("serial data path wrong");

   // an unmasked event asserts interrupt within two cycles
   a_irq_assert: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
      |(ev & mask_q) && $stable(mask_q) |-> ##[1:2] irq_oe_o && !irq_n_o)
      else $error("interrupt not asserted");

   // with the timer selector clear pin 1 keeps its mode
   a_no_alt: assert property (@(posedge clk_i) disable iff (rst_i) // see (R09)
      !tmr2_q[ALT_BIT] && mode_q[3:2] == MODE_INPUT |=> !gpio_oe_o[1])
      else $error("pin 1 driven with selector clear");

   // ack lasts exactly one cycle
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   // a fresh request is answered in the next cycle
   a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acknowledged");

   // reference clock also reaches pin 8
   a_refclk_pin8: assert property (@(posedge clk_i) disable iff (rst_i) // see (R02)
      txs_q[ALT_BIT] && $stable(txs_q) |=> gpio_o[8] == $past(ref_clk_i) && gpio_oe_o[8])
      else $error("reference clock not on pin 8");

   // an input pin with no alternate function is not driven
   a_input_undriven: assert property (@(posedge clk_i) disable iff (rst_i) // see (R01)
      mode_q[1:0] == MODE_INPUT && !txs_q[ALT_BIT] |=> !gpio_oe_o[0])
      else $error("input pin 0 driven");

   // a status bit stays set until a status read
   a_stat_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
      !rd_stat |=> (stat_q & $past(stat_q)) == $past(stat_q))
      else $error("status bit lost without a read");

   // an event is recorded even when a read clears in that cycle
   a_event_wins: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
      (|ev) |=> (stat_q & $past(ev)) == $past(ev))
      else $error("event lost against status clear");

   // no pending unmasked status releases the interrupt
   a_irq_release: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
      !(|(stat_q & mask_q)) |=> !irq_oe_o)
      else $error("interrupt held without pending status");
endmodule

// ### inc/ugpfm_pkg.sv
// constants, modes and carriers of the pin-function mux
// assumes a 32-bit classic wishbone register bus
package ugpfm_pkg;
   localparam int NPINS = 9;
   localparam int ALT_BIT = 7;
   localparam int RTS_BIT = 1;
   // register byte offsets
   localparam logic [7:0] OFS_PIN_MODE = 8'h00;
   localparam logic [7:0] OFS_PIN_OUT  = 8'h04;
   localparam logic [7:0] OFS_PIN_IN   = 8'h08;
   localparam logic [7:0] OFS_TX_SYNC  = 8'h0c;
   localparam logic [7:0] OFS_SECOND_TIMER_CONTROL   = 8'h10;
   localparam logic [7:0] OFS_CLK_SRC  = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
   localparam logic [7:0] OFS_CTS_STAT = 8'h20;
   localparam logic [7:0] OFS_LINE_CTL = 8'h24;
   // pins that carry the alternate signals
   localparam logic [8:0] REFCLK_PINS = 9'h111;
   localparam logic [8:0] TIMER_PINS  = 9'h022;
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [7:0]  RST_LCR  = 8'h02;
   typedef enum logic [1:0]
   {
      MODE_INPUT = 2'h0,
      MODE_PUSH  = 2'h1,
      MODE_DRAIN = 2'h2,
      MODE_EVENT = 2'h3
   } ugpfm_mode_e;
   typedef struct packed
   {
      logic [7:0]  adr;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] dat;
   } ugpfm_wb_req_s;
   typedef struct packed
   {
      ugpfm_mode_e mode;
      logic        level;
      logic        alt_en;
      logic        alt_val;
   } ugpfm_pin_cfg_s;
endpackage

// ### hw/ugpfm_wb_slave.sv
// classic wishbone slave handshake for the mux registers
// assumes the master holds its request until it sees ack
`timescale 1ns/1ps
module ugpfm_wb_slave
   import ugpfm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] rdata_i,
   output logic             ack_o,
   output logic [31:0]      dat_o,
   output logic             wr_o,
   output logic             rd_o
);
   logic ack_q;
   logic req;

   // request seen and not yet answered
   assign req = cyc_i & stb_i & ~ack_q;

   // ack one cycle after the request, dropped next cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_q <= 1'b0;
      else
         ack_q <= req;
   end

   // read data latched when the request is taken
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= RST_ZERO;
      else if (req)
         dat_o <= we_i ? RST_ZERO : rdata_i;
   end

   // commit strobes fall on the edge the master sees ack
   assign ack_o = ack_q;
   assign wr_o  = ack_q & cyc_i & stb_i & we_i;
   assign rd_o  = ack_q & cyc_i & stb_i & ~we_i;
endmodule

// ### hw/ugpfm_pin_cell.sv
// one general pin: drive, open drain, input or event source
// assumes the pin level arrives synchronous to clk_i
`timescale 1ns/1ps
module ugpfm_pin_cell
   import ugpfm_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire ugpfm_pin_cfg_s cfg_i,
   input  wire logic           pin_i,
   output logic                pin_o,
   output logic                pin_oe_o,
   output logic                level_o,
   output logic                event_o
);
   // output stage, alternate signal overrides the mode
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_o    <= 1'b0;
         pin_oe_o <= 1'b0;
      end
      else if (cfg_i.alt_en)
      begin
         pin_o    <= cfg_i.alt_val;
         pin_oe_o <= 1'b1;
      end
      else
      begin
         unique case (cfg_i.mode)
            MODE_PUSH:
            begin
               pin_o    <= cfg_i.level;
               pin_oe_o <= 1'b1;
            end
            MODE_DRAIN:
            begin
               pin_o    <= 1'b0;
               pin_oe_o <= ~cfg_i.level; // pull low only
            end
            MODE_INPUT, MODE_EVENT:
            begin
               pin_o    <= 1'b0;
               pin_oe_o <= 1'b0;
            end
         endcase
      end
   end

   // input sample and change detect for event mode
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         level_o <= 1'b0;
         event_o <= 1'b0;
      end
      else
      begin
         level_o <= pin_i;
         event_o <= (cfg_i.mode == MODE_EVENT) & (pin_i != level_o);
      end
   end
endmodule

// ### testbench/ugpfm_top_tb.sv
// self-checking bench for the pin-function mux top
// assumes ugpfm_pkg and a 1-cycle wishbone ack
`timescale 1ns/1ps
module ugpfm_top_tb
   import ugpfm_pkg::*;
;
   typedef struct
   {
      logic [31:0] mode;
      logic [31:0] out;
      logic        ref_v;
      logic        tim_v;
      logic [31:0] txs;
      logic [31:0] tm2;
      logic [8:0]  exp_o;
      logic [8:0]  exp_oe;
   } ugpfm_row_s;
   logic             clk_i;
   logic             rst_i;
   logic             cyc_i;
   logic             stb_i;
   logic             we_i;
   logic [7:0]       adr_i;
   logic [3:0]       sel_i;
   logic [31:0]      dat_i;
   logic             ack_o;
   logic [31:0]      dat_o;
   logic             ref_clk_i;
   logic             timer_i;
   logic [1:0]       uart_clk_i;
   logic [1:0]       cts_n_i;
   logic [1:0]       uart_cts_n_o;
   logic [1:0]       rx_i;
   logic [1:0]       uart_rxd_o;
   logic [1:0]       uart_txd_i;
   logic [1:0]       tx_o;
   logic [1:0]       rts_n_o;
   logic [NPINS-1:0] gpio_i;
   logic [NPINS-1:0] gpio_o;
   logic [NPINS-1:0] gpio_oe_o;
   logic             irq_n_o;
   logic             irq_oe_o;
   int               miscompares;
   int               num_checks;
   logic [31:0]      rd;
   // pin table: mode, out, ref, timer, tx sync, second_timer_control, pin value, pin enable
   ugpfm_row_s rows [10] = '{
      '{32'h0, 32'h1ff, 1'b0, 1'b0, 32'h0, 32'h0, 9'h000, 9'h000},
      '{32'h15555, 32'h155, 1'b0, 1'b0, 32'h0, 32'h0, 9'h155, 9'h1ff},
      '{32'h15555, 32'h0aa, 1'b0, 1'b0, 32'h0, 32'h0, 9'h0aa, 9'h1ff},
      '{32'h2aaaa, 32'h155, 1'b0, 1'b0, 32'h0, 32'h0, 9'h000, 9'h0aa},
      '{32'h3ffff, 32'h1ff, 1'b0, 1'b0, 32'h0, 32'h0, 9'h000, 9'h000},
      '{32'h15555, 32'h0, 1'b1, 1'b0, 32'h80, 32'h0, 9'h111, 9'h1ff},
      '{32'h15555, 32'h0, 1'b0, 1'b0, 32'h80, 32'h0, 9'h000, 9'h1ff},
      '{32'h15555, 32'h0, 1'b0, 1'b1, 32'h0, 32'h80, 9'h022, 9'h1ff},
      '{32'h0, 32'h0, 1'b1, 1'b1, 32'h80, 32'h80, 9'h133, 9'h133},
      '{32'h15555, 32'h0, 1'b1, 1'b1, 32'h7f, 32'h7f, 9'h000, 9'h1ff}};

   ugpfm_top #(.NUART(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
      .ref_clk_i(ref_clk_i), .timer_i(timer_i), .uart_clk_i(uart_clk_i), .gpio_i(gpio_i),
      .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o), .rts_n_o(rts_n_o), .cts_n_i(cts_n_i),
      .uart_cts_n_o(uart_cts_n_o), .rx_i(rx_i), .uart_rxd_o(uart_rxd_o), .uart_txd_i(uart_txd_i),
      .tx_o(tx_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o));

   // 250 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // counts and verdict, the only way out of the run
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one comparison
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // classic single wishbone cycle, held until ack is sampled
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      if (n >= 20)
      begin
         $display("CHECK FAILED ack expected 1 seen timeout");
         miscompares++;
         stop_test();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(a, 1'b0, 32'h0, q);
      chk(name, exp, q);
   endtask

   // main sequence
   initial
   begin
      {cyc_i, stb_i, we_i, ref_clk_i, timer_i} = 5'h00;
      adr_i = 8'h00;
      sel_i = 4'h0;
      dat_i = 32'h0;
      uart_clk_i = 2'h0;
      cts_n_i = 2'h3;
      rx_i = 2'h3;
      uart_txd_i = 2'h3;
      gpio_i = 9'h000;
      miscompares = 0;
      num_checks = 0;
      rst_i = 1'b1;
      tick(20);
      chk("rts_reset", 32'h3, {30'h0, rts_n_o});
      chk("oe_reset", 32'h0, {23'h0, gpio_oe_o});
      chk("irq_reset", 32'h0, {31'h0, irq_oe_o});
      rst_i <= 1'b0;
      rd_chk("lcr0_reset", OFS_LINE_CTL, 32'h2);
      rd_chk("lcr1_reset", OFS_LINE_CTL + 8'h04, 32'h2);
      $display("test reset done");
      foreach (rows[i])
      begin
         @(posedge clk_i);
         ref_clk_i <= rows[i].ref_v;
         timer_i   <= rows[i].tim_v;
         wb(OFS_PIN_MODE, 1'b1, rows[i].mode, rd);
         wb(OFS_PIN_OUT, 1'b1, rows[i].out, rd);
         wb(OFS_TX_SYNC, 1'b1, rows[i].txs, rd);
         wb(OFS_SECOND_TIMER_CONTROL, 1'b1, rows[i].tm2, rd);
         tick(3);
         chk("pin_oe", {23'h0, rows[i].exp_oe}, {23'h0, gpio_oe_o});
         chk("pin_out", {23'h0, rows[i].exp_o}, {23'h0, gpio_o & rows[i].exp_oe});
      end
      $display("test pin table done");
      wb(OFS_LINE_CTL, 1'b1, 32'h0, rd);
      tick(3);
      chk("rts_lcr0", 32'h2, {30'h0, rts_n_o});
      wb(OFS_LINE_CTL + 8'h04, 1'b1, 32'h0, rd);
      wb(OFS_LINE_CTL, 1'b1, 32'h2, rd);
      tick(3);
      chk("rts_lcr1", 32'h1, {30'h0, rts_n_o});
      uart_clk_i <= 2'h2;
      wb(OFS_CLK_SRC, 1'b1, 32'h80, rd);
      tick(3);
      chk("rts_clk_a", 32'h2, {30'h0, rts_n_o});
      uart_clk_i <= 2'h0;
      tick(3);
      chk("rts_clk_b", 32'h0, {30'h0, rts_n_o});
      wb(OFS_CLK_SRC, 1'b1, 32'h7f, rd);
      tick(3);
      chk("rts_clk_off", 32'h1, {30'h0, rts_n_o});
      cts_n_i <= 2'h1;
      rx_i <= 2'h1;
      uart_txd_i <= 2'h2;
      tick(3);
      chk("cts_core", 32'h1, {30'h0, uart_cts_n_o});
      chk("rxd_core", 32'h1, {30'h0, uart_rxd_o});
      chk("txd_line", 32'h2, {30'h0, tx_o});
      rd_chk("cts_stat", OFS_CTS_STAT, 32'h1);
      $display("test uart pins done");
      wb(OFS_PIN_MODE, 1'b1, 32'h0, rd);
      gpio_i <= 9'h0a5;
      wb(OFS_PIN_IN, 1'b1, 32'h0, rd);
      tick(3);
      rd_chk("pin_in", OFS_PIN_IN, 32'h0a5);
      wb(8'h80, 1'b1, 32'hffff_ffff, rd);
      rd_chk("unmapped", 8'h80, 32'h0);
      wb(OFS_PIN_MODE, 1'b1, 32'h30, rd);
      tick(3);
      // pin 2 event lands while this read clears the older cts change
      gpio_i <= 9'h0a9;
      rd_chk("stat_cts", OFS_IRQ_STAT, 32'h400);
      tick(4);
      chk("irq_masked", 32'h0, {31'h0, irq_oe_o});
      rd_chk("stat_event", OFS_IRQ_STAT, 32'h4);
      rd_chk("stat_clear", OFS_IRQ_STAT, 32'h0);
      wb(OFS_IRQ_MASK, 1'b1, 32'h4, rd);
      chk("irq_idle", 32'h0, {31'h0, irq_oe_o});
      gpio_i <= 9'h0ad;
      tick(4);
      chk("irq_oe", 32'h1, {31'h0, irq_oe_o});
      chk("irq_level", 32'h0, {31'h0, irq_n_o});
      rd_chk("stat_event2", OFS_IRQ_STAT, 32'h4);
      tick(3);
      chk("irq_released", 32'h0, {31'h0, irq_oe_o});
      $display("test interrupt done");
      stop_test();
   end
endmodule
